// ==== sxa_signaling_extract_access.sv ====
// register access, change flags and receive conditioning of the signaling extractor
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
module sxa_signaling_extract_access
	import sxa_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rstn_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// extracted signaling from the line side
	input wire logic sig_valid_in,
	input wire logic [4:0] sig_slot_in,
	input wire logic [3:0] sig_abcd_in,
	input wire logic mf_start_in,
	// receive pcm stream
	input wire logic pcm_valid_in,
	input wire logic [4:0] pcm_slot_in,
	input wire logic [7:0] pcm_data_in,
	input wire logic pcm_sigframe_in,
	input wire logic sign_invert_in,
	input wire logic mw_insert_in,
	input wire logic [7:0] mw_byte_in,
	input wire logic trunk_insert_in,
	input wire logic [7:0] trunk_byte_in,
	output logic pcm_valid_out,
	output logic [7:0] pcm_data_out
);

	initial begin
		if (ADDR_W < 10 || ADDR_W > 32) begin
			$error("ADDR_W must lie between 10 and 32");
		end
	end

	// ****************************************
	// state
	// ****************************************
	logic [7:0] mode_q, cfg_q, data_q, rdata;
	logic [6:0] iaddr_q;
	logic ird_q, pready_q, pslverr_q;
	logic [31:0] prdata_q;
	sxa_ind_e ist_q;
	logic [15:0] flags_q, set_v, clr_v;
	logic [3:0] cur_q [32];
	logic [3:0] prev_q [32];
	logic [3:0] stage_q [32];
	logic [3:0] dly_q [32];
	logic [3:0] psc_q [32];
	logic pcm_valid_q;
	logic [7:0] pcm_data_q;

	wire logic e1 = mode_q[SXA_MODE_E1_BIT];
	wire logic view = cfg_q[SXA_CFG_VIEW_BIT];
	wire logic slot_en = cfg_q[SXA_CFG_SLOT_EN_BIT];
	wire logic busy = (ist_q == SXA_RUN);

	// ****************************************
	// apb decode
	// ****************************************
	logic [ADDR_W-3:0] idx;
	logic hit_mode, hit_cfg, hit_stat, hit_actl, hit_data, mapped, done, wr_ok, start;
	assign idx = paddr_in[ADDR_W-1:2];
	assign hit_mode = (idx == (ADDR_W-2)'(SXA_IDX_MODE));
	assign hit_cfg = (idx == (ADDR_W-2)'(SXA_IDX_CFG));
	assign hit_stat = (idx == (ADDR_W-2)'(SXA_IDX_STAT));
	assign hit_actl = (idx == (ADDR_W-2)'(SXA_IDX_ACTL));
	assign hit_data = (idx == (ADDR_W-2)'(SXA_IDX_DATA));
	assign mapped = (paddr_in[1:0] == 2'h0)
		&& (hit_mode || hit_cfg || hit_stat || hit_actl || hit_data);
	// one wait state: the answer is registered, so every output comes from a flop
	assign start = psel_in && penable_in && !pready_q;
	assign done = psel_in && penable_in && pready_q;
	assign wr_ok = done && pwrite_in && mapped;
	always_comb begin
		rdata = 8'h00;
		if (hit_mode) begin
			rdata = mode_q;
		end else if (hit_cfg) begin
			rdata = view ? (8'h01 << SXA_CFG_VIEW_BIT) : cfg_q;
		end else if (hit_stat) begin
			rdata = view ? 8'h00 : ({7'h00, busy} << SXA_STAT_BUSY_BIT);
		end else if (hit_actl) begin
			rdata = view ? flags_q[15:8] : {ird_q, iaddr_q};
		end else if (hit_data) begin
			rdata = view ? flags_q[7:0] : data_q;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= start;
			pslverr_q <= start && !mapped;
			if (start) begin
				prdata_q <= (!pwrite_in && mapped) ? {24'h0, rdata} : 32'h0;
			end
		end
	end

	// ****************************************
	// direct registers
	// ****************************************
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			mode_q <= SXA_MODE_RST;
			cfg_q <= SXA_CFG_RST;
		end else if (wr_ok && hit_mode) begin
			mode_q <= pwdata_in[7:0];
		end else if (wr_ok && hit_cfg) begin
			if (view) begin
				cfg_q[SXA_CFG_VIEW_BIT] <= pwdata_in[SXA_CFG_VIEW_BIT];
			end else begin
				cfg_q <= pwdata_in[7:0];
			end
		end
	end

	// ****************************************
	// indirect access engine
	// ****************************************
	logic [7:0] ind_rdata;
	logic launch;
	logic [4:0] di;
	assign di = iaddr_q[4:0];
	// a launch while busy is dropped: the host is expected to poll busy first
	assign launch = wr_ok && hit_actl && !view && !busy;
	always_comb begin
		ind_rdata = 8'h00;
		if (iaddr_q >= SXA_IND_CUR && iaddr_q < SXA_IND_DLY) begin
			ind_rdata[7:4] = (e1 && di[3:0] == 4'h0) ? 4'h0 : cur_q[{1'b0, di[3:0]}];
			ind_rdata[3:0] = (e1 && di[3:0] == 4'h0) ? 4'h0 : cur_q[{1'b1, di[3:0]}];
		end else if (iaddr_q < SXA_IND_PSC) begin
			if (e1 ? (di[3:0] != 4'h0) : (di < SXA_T1_CHANS)) begin
				ind_rdata = {4'h0, dly_q[di]};
			end
		end else if (iaddr_q < SXA_IND_END) begin
			ind_rdata = {4'h0, psc_q[di]};
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			ist_q <= SXA_IDLE;
			iaddr_q <= 7'h00;
			ird_q <= 1'b0;
		end else begin
			case (ist_q)
				SXA_IDLE: begin
					if (launch) begin
						iaddr_q <= pwdata_in[6:0];
						ird_q <= pwdata_in[SXA_ACTL_RD_BIT];
						// the low segment holds direct registers, so nothing starts there
						ist_q <= (pwdata_in[6:0] >= SXA_IND_CUR) ? SXA_RUN : SXA_IDLE;
					end
				end
				SXA_RUN: begin
					ist_q <= SXA_IDLE;
				end
				default: begin
					ist_q <= SXA_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			data_q <= SXA_DATA_RST;
		end else if (busy && ird_q) begin
			data_q <= ind_rdata;
		end else if (wr_ok && hit_data && !view) begin
			data_q <= pwdata_in[7:0];
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < 32; i++) begin
				psc_q[i] <= 4'h0;
			end
		end else if (busy && !ird_q && iaddr_q >= SXA_IND_PSC && iaddr_q < SXA_IND_END) begin
			psc_q[di] <= data_q[3:0];
		end
	end

	// ****************************************
	// signaling capture, debounce and change flags
	// ****************************************
	logic [3:0] psc_s, raw, newv;
	logic slot_ok, changed;
	logic [5:0] fk;
	assign psc_s = slot_en ? psc_q[sig_slot_in] : 4'h0;
	assign raw = sig_abcd_in;
	assign slot_ok = e1 ? (sig_slot_in[3:0] != 4'h0) : (sig_slot_in < SXA_T1_CHANS);
	always_comb begin
		newv = raw;
		for (int b = 0; b < 4; b++) begin
			if (psc_s[SXA_PSC_DEB] && raw[b] != prev_q[sig_slot_in][b]) begin
				newv[b] = cur_q[sig_slot_in][b];
			end
		end
	end
	assign changed = sig_valid_in && slot_ok && (newv != cur_q[sig_slot_in]);
	always_comb begin
		set_v = 16'h0;
		if (e1) begin
			fk = (sig_slot_in < SXA_E1_SIG_TS) ? {1'b0, sig_slot_in} : {1'b0, sig_slot_in} - 6'd1;
		end else begin
			fk = {1'b0, sig_slot_in} + 6'd1;
		end
		if (changed && fk >= 6'd1 && fk <= 6'd16) begin
			set_v[4'(fk - 6'd1)] = 1'b1;
		end
	end

	// only the bits the host actually saw as set are cleared
	always_comb begin
		clr_v = 16'h0;
		if (done && !pwrite_in && mapped && view && hit_actl) begin
			clr_v[15:8] = prdata_q[7:0];
		end else if (done && !pwrite_in && mapped && view && hit_data) begin
			clr_v[7:0] = prdata_q[7:0];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			flags_q <= 16'h0;
		end else begin
			flags_q <= (flags_q & ~clr_v) | set_v;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < 32; i++) begin
				cur_q[i] <= 4'h0;
				prev_q[i] <= 4'h0;
			end
		end else if (sig_valid_in && slot_ok) begin
			prev_q[sig_slot_in] <= raw;
			cur_q[sig_slot_in] <= newv;
		end
	end

	// two-stage copy so the delayed view lags a whole multiframe
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < 32; i++) begin
				stage_q[i] <= 4'h0;
				dly_q[i] <= 4'h0;
			end
		end else if (mf_start_in) begin
			for (int i = 0; i < 32; i++) begin
				stage_q[i] <= cur_q[i];
				dly_q[i] <= stage_q[i];
			end
		end
	end

	// ****************************************
	// receive pcm conditioning
	// ****************************************
	logic [3:0] psc_p;
	logic [7:0] fixed, mask, pcm_d;
	logic fix_on;
	assign psc_p = slot_en ? psc_q[pcm_slot_in] : 4'h0;
	assign fix_on = !e1 && psc_p[SXA_PSC_INV_LO] && pcm_sigframe_in;

	always_comb begin
		fixed = pcm_data_in;
		if (fix_on) begin
			fixed[0] = psc_p[SXA_PSC_POL];
		end
		if (e1) begin
			case (psc_p[SXA_PSC_INV_HI:SXA_PSC_INV_LO])
				2'b01: mask = SXA_MASK_EVEN;
				2'b10: mask = SXA_MASK_ODD;
				2'b11: mask = SXA_MASK_ALL;
				default: mask = 8'h00;
			endcase
		end else begin
			case ({psc_p[SXA_PSC_INV_HI], sign_invert_in})
				2'b10: mask = SXA_MASK_ALL;
				2'b01: mask = SXA_MASK_SIGN;
				2'b11: mask = SXA_MASK_MAG;
				default: mask = 8'h00;
			endcase
		end
		if (mw_insert_in) begin
			pcm_d = mw_byte_in;
		end else if (trunk_insert_in) begin
			pcm_d = trunk_byte_in;
		end else begin
			pcm_d = fixed ^ mask;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			pcm_valid_q <= 1'b0;
			pcm_data_q <= 8'h00;
		end else begin
			pcm_valid_q <= pcm_valid_in;
			if (pcm_valid_in) begin
				pcm_data_q <= pcm_d;
			end
		end
	end

	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign pcm_valid_out = pcm_valid_q;
	assign pcm_data_out = pcm_data_q;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	property p_flag_keep;
		set_v[0] |=> flags_q[0];
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("flag set lost");
	property p_busy_one;
		launch && pwdata_in[6:0] >= SXA_IND_CUR |=> busy ##1 !busy;
	endproperty
	a_busy_one: assert property (p_busy_one) else $error("busy timing wrong");
	property p_launch_low;
		launch && pwdata_in[6:0] < SXA_IND_CUR |=> !busy [*2];
	endproperty
	a_launch_low: assert property (p_launch_low) else $error("low segment launched");
	property p_no_ts16;
		e1 && sig_valid_in && sig_slot_in == SXA_E1_SIG_TS |=> $stable(cur_q[16]);
	endproperty
	a_no_ts16: assert property (p_no_ts16) else $error("slot 16 captured in E1");
	property p_ind_read;
		busy && ird_q |=> data_q == $past(ind_rdata);
	endproperty
	a_ind_read: assert property (p_ind_read) else $error("read data not buffered");
	property p_mw_first;
		pcm_valid_in && mw_insert_in |=> pcm_data_out == $past(mw_byte_in);
	endproperty
	a_mw_first: assert property (p_mw_first) else $error("milliwatt not first");
	property p_bit_fix;
		pcm_valid_in && fix_on && !mw_insert_in && !trunk_insert_in && mask[0] == 1'b0
			|=> pcm_data_out[0] == $past(psc_p[SXA_PSC_POL]);
	endproperty
	a_bit_fix: assert property (p_bit_fix) else $error("signaling bit not fixed");
	property p_rd_clear;
		clr_v[7:0] != 8'h00 && set_v[7:0] == 8'h00 |=> (flags_q[7:0] & $past(clr_v[7:0])) == 8'h00;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared");
	property p_apb_wait;
		start |=> pready_out ##1 !pready_out;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing");

endmodule // sxa_signaling_extract_access

// ==== sxa_pkg.sv ====
// constants, field positions and types for the signaling extractor access block
package sxa_pkg;

	// ****************************************
	// register word indices (byte address is four times the index)
	// ****************************************
	localparam logic [7:0] SXA_IDX_MODE = 8'h4f;
	localparam logic [7:0] SXA_IDX_CFG = 8'h50;
	localparam logic [7:0] SXA_IDX_STAT = 8'h51;
	localparam logic [7:0] SXA_IDX_ACTL = 8'h52;
	localparam logic [7:0] SXA_IDX_DATA = 8'h53;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int SXA_MODE_E1_BIT = 0;
	localparam int SXA_CFG_VIEW_BIT = 6;
	localparam int SXA_CFG_SLOT_EN_BIT = 0;
	localparam int SXA_STAT_BUSY_BIT = 7;
	localparam int SXA_ACTL_RD_BIT = 7;
	localparam logic [7:0] SXA_MODE_RST = 8'h00;
	localparam logic [7:0] SXA_CFG_RST = 8'h00;
	localparam logic [7:0] SXA_DATA_RST = 8'h00;

	// ****************************************
	// indirect space segments
	// ****************************************
	localparam logic [6:0] SXA_IND_CUR = 7'h10;
	localparam logic [6:0] SXA_IND_DLY = 7'h20;
	localparam logic [6:0] SXA_IND_PSC = 7'h40;
	localparam logic [6:0] SXA_IND_END = 7'h60;
	localparam logic [4:0] SXA_T1_CHANS = 5'h18;
	localparam logic [4:0] SXA_E1_SIG_TS = 5'h10;

	// ****************************************
	// per-slot conditioning bits and masks
	// ****************************************
	localparam int SXA_PSC_INV_HI = 3;
	localparam int SXA_PSC_INV_LO = 2;
	localparam int SXA_PSC_POL = 1;
	localparam int SXA_PSC_DEB = 0;
	localparam logic [7:0] SXA_MASK_ALL = 8'hff;
	localparam logic [7:0] SXA_MASK_SIGN = 8'h80;
	localparam logic [7:0] SXA_MASK_MAG = 8'h7f;
	localparam logic [7:0] SXA_MASK_EVEN = 8'h55;
	localparam logic [7:0] SXA_MASK_ODD = 8'haa;

	typedef enum logic {
		SXA_IDLE = 1'b0,
		SXA_RUN = 1'b1
	} sxa_ind_e;

endpackage

// ==== sxa_apb_host.sv ====
// apb master model standing in for the host processor
`timescale 1ns/100ps
module sxa_apb_host (
	// clock
	input wire logic clk_in,
	// apb master side
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [11:0] paddr_out,
	output logic [31:0] pwdata_out,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in
);
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 12'h000;
		pwdata_out = 32'h0;
	end

	// ****************************************
	// one transfer, waiting as long as the slave needs
	// ****************************************
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
		output logic [7:0] q, output logic err);
		@(posedge clk_in);
		psel_out <= 1'b1;
		penable_out <= 1'b0;
		pwrite_out <= wr;
		paddr_out <= {2'b00, idx, 2'b00};
		pwdata_out <= {24'h0, d};
		@(posedge clk_in);
		penable_out <= 1'b1;
		do
			@(posedge clk_in);
		while (pready_in !== 1'b1);
		q = prdata_in[7:0];
		err = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		// released lines must not look like a held request
		paddr_out <= ~paddr_out;
		pwdata_out <= ~pwdata_out;
	endtask
endmodule // sxa_apb_host

// ==== tb_top.sv ====
// self-checking testbench of the signaling extractor access block
`timescale 1ns/100ps
module tb_top;
	import sxa_pkg::*;
	logic core_clk_in, rstn_in, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic sig_valid, mf_start, pcm_valid, pcm_sf, sign_inv, mw, tr, pcm_vo;
	logic [4:0] sig_slot, pcm_slot;
	logic [3:0] sig_abcd;
	logic [7:0] pcm_data, pcm_do;
	int n_errors = 0;
	int check_count = 0;
	localparam logic [7:0] T1_MASK [4] = '{8'h00, 8'h80, 8'hff, 8'h7f};
	localparam logic [7:0] E1_MASK [4] = '{8'h00, 8'h55, 8'haa, 8'hff};

	sxa_apb_host sxa_apb_host_i (.clk_in(core_clk_in), .psel_out(psel), .penable_out(penable),
		.pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
		.pready_in(pready), .pslverr_in(pslverr));

	sxa_signaling_extract_access sxa_signaling_extract_access_i (.core_clk_in(core_clk_in),
		.rstn_in(rstn_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .sig_valid_in(sig_valid), .sig_slot_in(sig_slot),
		.sig_abcd_in(sig_abcd), .mf_start_in(mf_start), .pcm_valid_in(pcm_valid),
		.pcm_slot_in(pcm_slot), .pcm_data_in(pcm_data), .pcm_sigframe_in(pcm_sf),
		.sign_invert_in(sign_inv), .mw_insert_in(mw), .mw_byte_in(8'h3c),
		.trunk_insert_in(tr), .trunk_byte_in(8'ha5), .pcm_valid_out(pcm_vo),
		.pcm_data_out(pcm_do));

	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end

	// ****************************************
	// checking and access tasks
	// ****************************************
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		logic er;
		sxa_apb_host_i.xfer(1'b1, idx, d, q, er);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic ee = 1'b0);
		logic [7:0] q;
		logic er;
		sxa_apb_host_i.xfer(1'b0, idx, 8'h00, q, er);
		chk($sformatf("word %h data", idx), e, q);
		chk($sformatf("word %h slverr", idx), {7'h0, ee}, {7'h0, er});
	endtask

	// the host must see the engine idle before touching the buffer again
	task automatic idle_wait();
		logic [7:0] q;
		logic er;
		do
			sxa_apb_host_i.xfer(1'b0, SXA_IDX_STAT, 8'h00, q, er);
		while (q[SXA_STAT_BUSY_BIT] !== 1'b0);
	endtask

	task automatic ind_wr(input logic [6:0] a, input logic [7:0] d);
		wr(SXA_IDX_DATA, d);
		wr(SXA_IDX_ACTL, {1'b0, a});
		idle_wait();
	endtask

	task automatic ind_rd(input logic [6:0] a, input logic [7:0] e);
		wr(SXA_IDX_ACTL, {1'b1, a});
		idle_wait();
		rd(SXA_IDX_DATA, e);
	endtask

	task automatic sig(input logic [4:0] s, input logic [3:0] v);
		@(posedge core_clk_in);
		sig_valid <= 1'b1;
		sig_slot <= s;
		sig_abcd <= v;
		@(posedge core_clk_in);
		sig_valid <= 1'b0;
	endtask

	task automatic mf();
		@(posedge core_clk_in);
		mf_start <= 1'b1;
		@(posedge core_clk_in);
		mf_start <= 1'b0;
	endtask

	task automatic pcm(input logic [7:0] d, input logic sf, input logic si, input logic m,
		input logic t, input logic [7:0] e);
		@(posedge core_clk_in);
		pcm_valid <= 1'b1;
		pcm_slot <= 5'd5;
		pcm_data <= d;
		pcm_sf <= sf;
		sign_inv <= si;
		mw <= m;
		tr <= t;
		@(posedge core_clk_in);
		pcm_valid <= 1'b0;
		#1;
		chk("pcm valid", 8'h01, {7'h0, pcm_vo});
		chk("pcm data", e, pcm_do);
	endtask

	// ****************************************
	// watchdog
	// ****************************************
	initial begin
		repeat (20000) @(posedge core_clk_in);
		n_errors++;
		finish_test();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{rstn_in, sig_valid, mf_start, pcm_valid, pcm_sf, sign_inv, mw, tr} = 8'h00;
		{sig_slot, pcm_slot, sig_abcd, pcm_data} = 22'h0;
		repeat (6) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		rd(SXA_IDX_MODE, SXA_MODE_RST);
		rd(SXA_IDX_CFG, SXA_CFG_RST);
		rd(SXA_IDX_DATA, SXA_DATA_RST);
		rd(8'h00, 8'h00, 1'b1);
		// a launch into the direct segment must not start the engine
		wr(SXA_IDX_DATA, 8'h5a);
		wr(SXA_IDX_ACTL, 8'h85);
		idle_wait();
		rd(SXA_IDX_DATA, 8'h5a);
		// t1: flag k follows channel k, storage index k-1
		sig(5'd2, 4'h5);
		sig(5'd12, 4'h9);
		sig(5'd16, 4'h9);
		wr(SXA_IDX_CFG, 8'h40);
		rd(SXA_IDX_ACTL, 8'h10);
		rd(SXA_IDX_DATA, 8'h04);
		rd(SXA_IDX_DATA, 8'h00);
		wr(SXA_IDX_CFG, 8'h00);
		ind_rd(7'h12, 8'h50);
		ind_rd(7'h10, 8'h09);
		ind_rd(7'h22, 8'h00);
		mf();
		ind_rd(7'h22, 8'h00);
		mf();
		ind_rd(7'h22, 8'h05);
		ind_rd(7'h38, 8'h00);
		ind_wr(7'h45, 8'hfb);
		ind_rd(7'h45, 8'h0b);
		wr(SXA_IDX_CFG, 8'h01);
		for (int i = 0; i < 4; i++) begin
			ind_wr(7'h45, {4'h0, i[1], 3'b000});
			pcm(8'h00, 1'b0, i[0], 1'b0, 1'b0, T1_MASK[i]);
		end
		pcm(8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 8'h3c);
		pcm(8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 8'ha5);
		ind_wr(7'h45, 8'h06);
		pcm(8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 8'h01);
		pcm(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
		ind_wr(7'h45, 8'h0c);
		pcm(8'hff, 1'b1, 1'b0, 1'b0, 1'b0, 8'h01);
		wr(SXA_IDX_CFG, 8'h00);
		pcm(8'h0f, 1'b1, 1'b0, 1'b0, 1'b0, 8'h0f);
		// e1 mode from here on
		wr(SXA_IDX_MODE, 8'h01);
		wr(SXA_IDX_CFG, 8'h01);
		for (int i = 0; i < 4; i++) begin
			ind_wr(7'h45, {4'h0, i[1], i[0], 2'b00});
			pcm(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, E1_MASK[i]);
		end
		ind_wr(7'h43, 8'h01);
		sig(5'd17, 4'h3);
		sig(5'd9, 4'h4);
		sig(5'd1, 4'h2);
		sig(5'd16, 4'h7);
		sig(5'd3, 4'h6);
		wr(SXA_IDX_CFG, 8'h41);
		rd(SXA_IDX_ACTL, 8'h81);
		rd(SXA_IDX_DATA, 8'h01);
		wr(SXA_IDX_CFG, 8'h01);
		sig(5'd3, 4'h6);
		wr(SXA_IDX_CFG, 8'h41);
		rd(SXA_IDX_DATA, 8'h04);
		wr(SXA_IDX_CFG, 8'h01);
		ind_rd(7'h10, 8'h00);
		ind_rd(7'h11, 8'h23);
		finish_test();
	end
endmodule // tb_top
